// ---- core/psp_pkg.sv ----
// shared constants and types of the programmable synchronous memory port
package psp_pkg;

  // -------------------------------------------------------------------------
  // widths
  // -------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 64;
  localparam int unsigned BE_W   = DATA_W / 8;
  localparam int unsigned REG_AW = 4;
  localparam int unsigned REG_DW = 32;

  // -------------------------------------------------------------------------
  // register map (byte addresses)
  // -------------------------------------------------------------------------
  localparam logic [REG_AW-1:0] OFS_CFG    = 4'h0;
  localparam logic [REG_AW-1:0] OFS_STATUS = 4'h4;
  localparam logic [REG_AW-1:0] OFS_RDATA  = 4'h8;

  // config field positions
  localparam int unsigned CFG_RL_LSB   = 0;
  localparam int unsigned CFG_WL_LSB   = 2;
  localparam int unsigned CFG_CHIP_ENABLE_EXTEND    = 4;
  localparam int unsigned CFG_FIFO_RD  = 5;
  localparam int unsigned CFG_CLK_SEL  = 6;
  localparam int unsigned CFG_SYNC_EN  = 7;
  localparam logic [7:0]  CFG_RESET    = 8'h80;

  // status field positions
  localparam int unsigned ST_BUSY    = 0;
  localparam int unsigned ST_PENDING = 1;

  localparam logic [1:0] DIV_ONE = 2'h1;

  // -------------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------------
  // packed msb first, so field order mirrors the config bit positions
  typedef struct packed {
    logic       sync_mode_en;
    logic       sync_clock_select;
    logic       strobe_as_fifo_read;
    logic       chip_enable_extend;
    logic [1:0] write_latency_sel;
    logic [1:0] read_latency_sel;
  } psp_cfg_type;

  typedef struct packed {
    logic              space_chip_enable_n;
    logic [BE_W-1:0]   ext_byte_enables_n;
    logic [ADDR_W-1:0] ext_address_bus;
    logic [DATA_W-1:0] ext_data_out;
    logic              ext_data_oe_n;
    logic              addr_strobe_or_read_en_n;
    logic              sync_output_enable_n;
    logic              sync_write_enable_n;
  } psp_pins_type;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [BE_W-1:0]   be;
  } psp_req_type;

  localparam psp_pins_type PINS_IDLE = '{
    space_chip_enable_n:      1'b1,
    ext_byte_enables_n:       '1,
    ext_address_bus:          '0,
    ext_data_out:             '0,
    ext_data_oe_n:            1'b1,
    addr_strobe_or_read_en_n: 1'b1,
    sync_output_enable_n:     1'b1,
    sync_write_enable_n:      1'b1
  };

endpackage : psp_pkg

// ---- core/psp_sync_port.sv ----
// programmable synchronous interface control for an external memory port
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Overview of operation
// - read latency selectable zero to three cycles
// - write latency selectable zero to three cycles
// - extend off: chip enable drops after command
// - extend on: chip enable follows output enable
// - strobe as address strobe, with deselect cycle
// - strobe as fifo read enable, no deselect
// - software picks one of two output clocks
// - three strobe pins reused in synchronous mode
// - outputs launched on selected clock rising edge
// - read data captured on selected rising edge
// - clock enable output only on wide port
// ---------------------------------------------------------------------------
module psp_sync_port #(
  parameter bit WIDE_PORT = 1'b1
) (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic [psp_pkg::REG_AW-1:0]   reg_addr,
  input  wire logic [psp_pkg::REG_DW-1:0]   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [psp_pkg::REG_DW-1:0]   reg_rdata,
  input  wire logic                         req_valid,
  input  wire psp_pkg::psp_req_type         req,
  output logic                              req_ready,
  output logic                              rsp_valid,
  output logic      [psp_pkg::DATA_W-1:0]   rsp_data,
  input  wire logic [2:0]                   alt_strobes_n,
  input  wire logic [psp_pkg::DATA_W-1:0]   ext_data_in,
  output psp_pkg::psp_pins_type             pins,
  output logic                              iface_out_clock_one,
  output logic                              iface_out_clock_two,
  output logic                              sdram_clock_enable_wide
);
  import psp_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_XFER  = 4'b0010,
    ST_DESEL = 4'b0100,
    ST_SPARE = 4'b1000
  } psp_state_type;

  // -------------------------------------------------------------------------
  // output clock dividers and launch tick
  // -------------------------------------------------------------------------
  logic [1:0] div_q, div_d;
  logic       clk_one_q, clk_two_q, tick;

  always_comb begin
    div_d = div_q + DIV_ONE;
  end

  psp_cfg_type cfg_q, cfg_d;

  // both clocks run free; only the selected one times accesses
  assign tick = cfg_q.sync_clock_select ? (div_d == 2'h2) : div_d[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q     <= '0;
      clk_one_q <= 1'b0;
      clk_two_q <= 1'b0;
    end else begin
      div_q     <= div_d;
      clk_one_q <= div_d[0];
      clk_two_q <= div_d[1];
    end
  end

  // -------------------------------------------------------------------------
  // register port
  // -------------------------------------------------------------------------
  logic [REG_DW-1:0] rdata_q, rdata_d;
  logic [DATA_W-1:0] last_q, last_d;
  logic              busy;
  logic              pend_q, pend_d;

  function automatic logic hit(input logic [REG_AW-1:0] a, input logic [REG_AW-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  always_comb begin
    cfg_d   = cfg_q;
    rdata_d = '0;
    if (reg_wr && hit(reg_addr, OFS_CFG)) begin
      cfg_d = psp_cfg_type'(reg_wdata[CFG_SYNC_EN:CFG_RL_LSB]);
    end
    if (reg_rd) begin
      if (hit(reg_addr, OFS_CFG)) begin
        rdata_d[CFG_SYNC_EN:CFG_RL_LSB] = cfg_q;
      end else if (hit(reg_addr, OFS_STATUS)) begin
        rdata_d[ST_BUSY]    = busy;
        rdata_d[ST_PENDING] = pend_q;
      end else if (hit(reg_addr, OFS_RDATA)) begin
        rdata_d = last_q[REG_DW-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q   <= psp_cfg_type'(CFG_RESET);
      rdata_q <= '0;
    end else begin
      cfg_q   <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  // -------------------------------------------------------------------------
  // access sequencer
  // -------------------------------------------------------------------------
  psp_state_type state_q, state_d;
  psp_req_type   acc_q, acc_d;
  psp_pins_type  pins_q, pins_d;
  logic [1:0]    cnt_q, cnt_d;
  logic          ready_q, ready_d;
  logic          rsp_q, rsp_d;
  logic [2:0]    alt_q, alt_d;

  assign busy = (state_q != ST_IDLE);

  always_comb begin
    state_d = state_q;
    acc_d   = acc_q;
    pins_d  = pins_q;
    cnt_d   = cnt_q;
    pend_d  = pend_q;
    last_d  = last_q;
    rsp_d   = 1'b0;
    alt_d   = alt_strobes_n;
    if (req_valid && ready_q) begin
      pend_d = 1'b1;
      acc_d  = req;
    end
    if (tick) begin
      case (state_q)
        ST_IDLE: begin
          if (pend_q && cfg_q.sync_mode_en) begin
            pend_d                          = 1'b0;
            state_d                         = ST_XFER;
            cnt_d                           = '0;
            pins_d.space_chip_enable_n      = 1'b0;
            pins_d.ext_address_bus          = acc_q.addr;
            pins_d.ext_byte_enables_n       = ~acc_q.be;
            pins_d.addr_strobe_or_read_en_n = 1'b0;
            pins_d.sync_output_enable_n     = acc_q.write;
            pins_d.sync_write_enable_n      = ~acc_q.write;
            pins_d.ext_data_out             = acc_q.wdata;
            pins_d.ext_data_oe_n            = ~(acc_q.write &&
                                                (cfg_q.write_latency_sel == 2'h0));
          end else begin
            // drop strobe levels left over from the other controllers
            pins_d = PINS_IDLE;
          end
        end
        ST_XFER: begin
          cnt_d                      = cnt_q + DIV_ONE;
          pins_d.sync_write_enable_n = 1'b1;
          // one command per access, so chip enable drops right after it, except on a read with chip_enable_extend set
          pins_d.space_chip_enable_n = ~(cfg_q.chip_enable_extend && !acc_q.write);
          pins_d.addr_strobe_or_read_en_n =
            ~(cfg_q.strobe_as_fifo_read && !acc_q.write);
          if (acc_q.write) begin
            pins_d.ext_data_oe_n = ~(cnt_d == cfg_q.write_latency_sel);
            if (cnt_q == cfg_q.write_latency_sel) begin
              pins_d  = PINS_IDLE;
              state_d = cfg_q.strobe_as_fifo_read ? ST_IDLE : ST_DESEL;
            end
          end else if (cnt_q == cfg_q.read_latency_sel) begin
            last_d  = ext_data_in;
            rsp_d   = 1'b1;
            pins_d  = PINS_IDLE;
            state_d = cfg_q.strobe_as_fifo_read ? ST_IDLE : ST_DESEL;
          end
        end
        ST_DESEL: begin
          // deselect: strobe low with chip enable high
          pins_d                          = PINS_IDLE;
          pins_d.addr_strobe_or_read_en_n = 1'b0;
          state_d                         = ST_SPARE;
        end
        ST_SPARE: begin
          pins_d  = PINS_IDLE;
          state_d = ST_IDLE;
        end
        default: begin
          pins_d  = PINS_IDLE;
          state_d = ST_IDLE;
        end
      endcase
    end
    ready_d = !pend_d && (state_d == ST_IDLE) && !(req_valid && ready_q);
    // outside synchronous mode the pins carry the other controllers' strobes
    if (!cfg_q.sync_mode_en) begin
      pins_d.addr_strobe_or_read_en_n = alt_q[0];
      pins_d.sync_output_enable_n     = alt_q[1];
      pins_d.sync_write_enable_n      = alt_q[2];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      acc_q   <= '0;
      pins_q  <= PINS_IDLE;
      cnt_q   <= '0;
      pend_q  <= 1'b0;
      last_q  <= '0;
      rsp_q   <= 1'b0;
      ready_q <= 1'b0;
      alt_q   <= '1;
    end else begin
      state_q <= state_d;
      acc_q   <= acc_d;
      pins_q  <= pins_d;
      cnt_q   <= cnt_d;
      pend_q  <= pend_d;
      last_q  <= last_d;
      rsp_q   <= rsp_d;
      ready_q <= ready_d;
      alt_q   <= alt_d;
    end
  end

  // -------------------------------------------------------------------------
  // clock enable for the wide port
  // -------------------------------------------------------------------------
  logic cke_q, cke_d;

  always_comb begin
    cke_d = cke_q;
    if (tick) begin
      cke_d = WIDE_PORT;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cke_q <= 1'b0;
    end else begin
      cke_q <= cke_d;
    end
  end

  assign reg_rdata               = rdata_q;
  assign req_ready               = ready_q;
  assign rsp_valid               = rsp_q;
  assign rsp_data                = last_q;
  assign pins                    = pins_q;
  assign iface_out_clock_one     = clk_one_q;
  assign iface_out_clock_two     = clk_two_q;
  assign sdram_clock_enable_wide = cke_q;

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  logic [2:0] since_q;
  logic       tick_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      since_q <= '0;
      tick_q  <= 1'b0;
    end else begin
      tick_q <= tick;
      if (tick && state_q == ST_IDLE) begin
        since_q <= '0;
      end else if (tick && since_q != 3'h7) begin
        since_q <= since_q + 3'h1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_read_done;
    rsp_q ##1 state_q != ST_XFER;
  endsequence

  a_read_latency: assert property ($rose(rsp_q) |->
    since_q == {1'b0, cfg_q.read_latency_sel} + 3'h1)
    else $error("read sampled at wrong tick");
  a_write_latency: assert property ($fell(pins_q.ext_data_oe_n) |->
    since_q == {1'b0, cfg_q.write_latency_sel} || state_q == ST_IDLE)
    else $error("write data at wrong tick");
  a_ce_short: assert property (
    (state_q == ST_XFER && !cfg_q.chip_enable_extend && since_q != 3'h0)
    |-> pins_q.space_chip_enable_n)
    else $error("chip enable held after command");
  a_ce_extend: assert property (
    (cfg_q.sync_mode_en && cfg_q.chip_enable_extend && !pins_q.sync_output_enable_n)
    |-> !pins_q.space_chip_enable_n)
    else $error("chip enable dropped while output enabled");
  a_deselect_cycle: assert property (state_q == ST_DESEL && tick
    |=> pins_q.space_chip_enable_n && !pins_q.addr_strobe_or_read_en_n)
    else $error("deselect cycle malformed");
  a_no_deselect: assert property (cfg_q.strobe_as_fifo_read && $stable(cfg_q)
    |-> state_q != ST_DESEL)
    else $error("deselect in fifo mode");
  a_launch_edge: assert property (
    (cfg_q.sync_mode_en && $changed(pins_q.ext_address_bus)) |-> tick_q)
    else $error("pins changed off the launch edge");
  a_capture_edge: assert property (s_read_done |-> $past(tick_q, 1))
    else $error("read data captured off edge");
  a_cke_narrow: assert property (!WIDE_PORT |-> !cke_q)
    else $error("clock enable on narrow port");

endmodule : psp_sync_port

// ---- tb/psp_mem_model.sv ----
// behavioural synchronous memory seen across the port pins
`timescale 1ns/1ps
module psp_mem_model
  import psp_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  out_clk,
  input  wire logic [1:0]            rl,
  input  wire logic [1:0]            wl,
  input  wire psp_pkg::psp_pins_type pins,
  output logic [psp_pkg::DATA_W-1:0] rd_data,
  output int                         err_count
);
  logic [DATA_W-1:0] mem [16];
  logic [3:0]        ra, wa;
  logic [1:0]        rcnt, wcnt;
  logic              prev_clk, rd_act, wr_act, tick, rd_cmd, wr_cmd;

  // ---------------------------------------------------------------------------
  // pins launched at a tick are taken one clk later
  // ---------------------------------------------------------------------------
  assign tick   = out_clk && !prev_clk;
  assign rd_cmd = !pins.space_chip_enable_n && !pins.sync_output_enable_n;
  assign wr_cmd = !pins.space_chip_enable_n && !pins.sync_write_enable_n;
  // valid only in the tick before sampling, inverted otherwise
  assign rd_data = (rd_act && rcnt == 2'h0) ? mem[ra] : ~mem[ra];

  initial begin
    err_count = 0;
    prev_clk  = 1'b0;
    rd_act    = 1'b0;
    wr_act    = 1'b0;
    ra        = 4'h0;
    foreach (mem[i]) mem[i] = '0;
  end

  task automatic take_data(input logic [3:0] a);
    if (!pins.ext_data_oe_n) mem[a] <= pins.ext_data_out;
    else err_count <= err_count + 1;
  endtask : take_data

  always @(posedge clk) begin
    prev_clk <= out_clk;
    if (tick) begin
      if (rd_act) begin
        if (rcnt == 2'h0) rd_act <= 1'b0;
        rcnt <= rcnt - 2'h1;
      end else if (rd_cmd && !pins.addr_strobe_or_read_en_n) begin
        rd_act <= 1'b1;
        rcnt   <= rl;
        ra     <= pins.ext_address_bus[3:0];
      end
      if (wr_act) begin
        if (wcnt == 2'h1) begin
          take_data(wa);
          wr_act <= 1'b0;
        end else if (!pins.ext_data_oe_n) err_count <= err_count + 1;
        wcnt <= wcnt - 2'h1;
      end else if (wr_cmd) begin
        wa <= pins.ext_address_bus[3:0];
        if (wl == 2'h0) take_data(pins.ext_address_bus[3:0]);
        else begin
          wr_act <= 1'b1;
          wcnt   <= wl;
        end
      end else if (!pins.ext_data_oe_n) err_count <= err_count + 1;
    end
  end
endmodule : psp_mem_model

// ---- tb/tb.sv ----
// self-checking bench for the programmable synchronous memory port
`timescale 1ns/1ps
module tb;
  import psp_pkg::*;
  logic              clk, rst_n, reg_wr, reg_rd, req_valid, req_ready;
  logic              rsp_valid, ck1, ck2, cke, sel, clr_cnt;
  logic [REG_AW-1:0] reg_addr;
  logic [REG_DW-1:0] reg_wdata, reg_rdata;
  logic [DATA_W-1:0] rsp_data, ext_data_in, d;
  logic [2:0]        alt_n;
  logic [1:0]        rl, wl;
  psp_req_type       req;
  psp_pins_type      pins;
  int                bad_count, checked, mod_err, ce_low, desel, oe_alone;

  psp_sync_port psp_sync_port_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .alt_strobes_n(alt_n), .ext_data_in(ext_data_in), .pins(pins),
    .iface_out_clock_one(ck1), .iface_out_clock_two(ck2), .sdram_clock_enable_wide(cke));
  psp_mem_model psp_mem_model_inst (.clk(clk), .out_clk(sel ? ck2 : ck1), .rl(rl),
    .wl(wl), .pins(pins), .rd_data(ext_data_in), .err_count(mod_err));

  always #2 clk = ~clk;

  // ---------------------------------------------------------------------------
  // pin activity counters
  // ---------------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n || clr_cnt) begin
      {ce_low, desel, oe_alone} <= {32'd0, 32'd0, 32'd0};
    end else begin
      if (!pins.space_chip_enable_n) ce_low <= ce_low + 1;
      if (pins.space_chip_enable_n && !pins.addr_strobe_or_read_en_n) desel <= desel + 1;
      if (pins.space_chip_enable_n && !pins.sync_output_enable_n) oe_alone <= oe_alone + 1;
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_check(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask : reg_check

  task automatic wait_idle();
    for (int n = 0; n < 300 && req_ready !== 1'b1; n++) @(posedge clk);
    check(64'(req_ready === 1'b1), 64'h1);
  endtask : wait_idle

  task automatic set_cfg(input logic [7:0] c);
    wait_idle();
    reg_write(OFS_CFG, {24'h0, c});
    {sel, rl, wl} <= {c[6], c[1:0], c[3:2]};
    clr_cnt <= 1'b1;
    @(posedge clk);
    clr_cnt <= 1'b0;
  endtask : set_cfg

  task automatic access(input logic w, input logic [3:0] a, input logic [63:0] v);
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= '{w, {16'h0, a}, v, 8'hff};
    @(posedge clk);
    for (int n = 0; n < 300 && req_ready !== 1'b1; n++) @(posedge clk);
    check(64'(req_ready === 1'b1), 64'h1);
    req_valid <= 1'b0;
  endtask : access

  task automatic wait_rsp(input logic [63:0] exp);
    for (int n = 0; n < 300; n++) begin
      @(posedge clk);
      #1;
      if (rsp_valid === 1'b1) break;
    end
    check(64'(rsp_valid === 1'b1), 64'h1);
    check(rsp_data, exp);
  endtask : wait_rsp

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_regs();
    reg_check(OFS_CFG, 32'h80);
    reg_check(OFS_STATUS, 32'h0);
    reg_write(4'hc, 32'hff);
    reg_check(4'hc, 32'h0);
    reg_check(OFS_CFG, 32'h80);
    check(cke, 1'b1);
  endtask : t_regs

  task automatic t_latency(input logic ck);
    for (int k = 0; k < 16; k++) begin
      set_cfg({1'b1, ck, 2'h0, k[3:0]});
      d = {8{k[7:0]}} ^ 64'ha5a5_0f0f_3c3c_9696;
      access(1'b1, k[3:0], d);
      access(1'b0, k[3:0], 64'h0);
      wait_rsp(d);
    end
    check(mod_err, 0);
  endtask : t_latency

  task automatic t_strobes();
    set_cfg(8'h82);
    access(1'b0, 4'h3, 64'h0);
    wait_rsp({8{8'h03}} ^ 64'ha5a5_0f0f_3c3c_9696);
    wait_idle();
    check(ce_low, 2);
    check(oe_alone, 4);
    check(desel, 2);
    set_cfg(8'hb2);
    access(1'b0, 4'h3, 64'h0);
    wait_rsp({8{8'h03}} ^ 64'ha5a5_0f0f_3c3c_9696);
    wait_idle();
    check(desel, 0);
    check(oe_alone, 0);
    check(ce_low, 6);
  endtask : t_strobes

  task automatic t_sync_off();
    set_cfg(8'h00);
    for (int k = 2; k < 6; k += 3) begin
      alt_n <= k[2:0];
      repeat (8) @(posedge clk);
      check({pins.sync_write_enable_n, pins.sync_output_enable_n,
             pins.addr_strobe_or_read_en_n}, k[2:0]);
    end
    d = {8{8'h0f}} ^ 64'ha5a5_0f0f_3c3c_9696;
    access(1'b0, 4'hf, 64'h0);
    reg_check(OFS_STATUS, 32'h2);
    reg_write(OFS_CFG, 32'h80);
    wait_rsp(d);
    reg_check(OFS_RDATA, d[31:0]);
  endtask : t_sync_off

  initial begin
    {clk, rst_n, reg_wr, reg_rd, req_valid, sel, rl, wl} = '0;
    {reg_addr, reg_wdata, req, bad_count, checked} = '0;
    clr_cnt = 1'b0;
    alt_n = 3'h7;
    repeat (4) @(posedge clk);
    #1 check(64'(pins === PINS_IDLE), 64'h1);
    check(req_ready, 1'b0);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_latency(1'b0);
    t_latency(1'b1);
    t_strobes();
    t_sync_off();
    summarize();
  end

  initial begin
    #200000;
    bad_count++;
    summarize();
  end
endmodule : tb
